/* rtl/pulse_width_period_meter.sv */
module pulse_width_period_meter
   import meter_pkg::*;
#(
   parameter int DEF_LIMIT_CYCLES = TIMEOUT_S * CLK_HZ,
   parameter int INT_TB_HZ        = CLK_HZ
) (
   input  wire logic                  clock_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  counter_gate_input_in,
   input  wire logic                  ext_timebase_in,
   input  wire logic [1:0]            meas_type_in,
   input  wire logic [31:0]           timebase_hz_in,
   input  wire logic                  cascade_in,
   input  wire logic                  use_default_limit_in,
   input  wire logic [31:0]           limit_cycles_in,
   input  wire logic                  start_in,
   input  wire logic                  read_ack_in,
   output logic      [31:0]           count_out,
   output logic      [TIME_OUT_W-1:0] time_ns_out,
   output logic                       valid_out,
   output logic                       overflow_out,
   output logic                       timeout_out,
   output logic                       done_out,
   output logic                       busy_out
);
   typedef struct packed {
      meter_state_e                    st;
      logic [2:0]                      gate_sync;
      logic [2:0]                      tb_sync;
      logic [SLICES-1:0][SLICE_W-1:0]  slice;
      logic                            ovf;
      logic [31:0]                     clk_cnt;
      logic [34:0]                     tick_cnt;
      logic                            div_start;
      logic [31:0]                     count;
      logic [TIME_OUT_W-1:0]           time_ns;
      logic                            valid;
      logic                            overflow;
      logic                            timeout;
      logic                            done;
      logic                            busy;
   } meter_s;

   meter_s r;
   meter_s next_r;

   logic              gate_rise;
   logic              gate_fall;
   logic              open_edge;
   logic              close_edge;
   logic              internal_tb;
   logic              tick;
   logic [SLICES:0]   carry;
   logic              at_tc;
   logic [31:0]       cur_count;
   logic              expired;
   logic [63:0]       quot;
   logic              div_done;
   logic [31:0]       den;

   // Edge rule for opening and closing the interval
   function automatic logic pick_edge(input logic [1:0] t, input logic rise,
                                      input logic fall, input logic closing);
      case (t)
         TYPE_HIGH_WIDTH: pick_edge = closing ? fall : rise;
         TYPE_LOW_WIDTH:  pick_edge = closing ? rise : fall;
         TYPE_RISE_PER:   pick_edge = rise;
         default:         pick_edge = fall;
      endcase
   endfunction

   // Gate edges from the synchronised pin
   assign gate_rise  = r.gate_sync[1] & ~r.gate_sync[2];
   assign gate_fall  = ~r.gate_sync[1] & r.gate_sync[2];
   assign open_edge  = pick_edge(meas_type_in, gate_rise, gate_fall, 1'b0);
   assign close_edge = pick_edge(meas_type_in, gate_rise, gate_fall, 1'b1);

   // Timebase source
   assign internal_tb = (timebase_hz_in == TB_INTERNAL_ZERO) ||
                        (timebase_hz_in == TB_INTERNAL_ALT);
   assign tick = internal_tb ? 1'b1 : (r.tb_sync[1] & ~r.tb_sync[2]);
   assign den  = internal_tb ? 32'(INT_TB_HZ) : timebase_hz_in;

   // Carry chain across the cascaded slices
   assign carry[0] = 1'b1;
   genvar gi;
   generate
      for (gi = 0; gi < SLICES; gi++) begin : g_carry
         assign carry[gi+1] = carry[gi] & (r.slice[gi] == {SLICE_W{1'b1}});
      end
   endgenerate

   // Terminal count of one slice or of the pair
   assign at_tc = cascade_in ? carry[SLICES] : carry[1];
   assign cur_count = cascade_in ?
                      ((32'(r.slice[1]) << CASCADE_SHIFT) + 32'(r.slice[0])) :
                      32'(r.slice[0]);

   // Time limit, default is the longer of the two bounds
   assign expired = use_default_limit_in ?
                    ((r.clk_cnt >= 32'(DEF_LIMIT_CYCLES)) &&
                     (r.tick_cnt >= (cascade_in ? TICK_LIMIT_TWO : TICK_LIMIT_ONE))) :
                    (r.clk_cnt >= limit_cycles_in);

   serial_divider #(
      .NUM_W (64),
      .DEN_W (32)
   ) u_div (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .start_in   (r.div_start),
      .num_in     (64'(r.count) * NS_PER_S),
      .den_in     (den),
      .quot_out   (quot),
      .done_out   (div_done)
   );

   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.gate_sync = {r.gate_sync[1:0], counter_gate_input_in};
      next_r.tb_sync   = {r.tb_sync[1:0], ext_timebase_in};
      next_r.div_start = 1'b0;
      if (r.st == ST_WAIT_OPEN || r.st == ST_COUNTING) begin
         next_r.clk_cnt = r.clk_cnt + 32'h1;
         if (tick) begin
            next_r.tick_cnt = r.tick_cnt + 35'h1;
         end
      end
      case (r.st)
         ST_IDLE: begin
            if (start_in) begin
               next_r.st       = ST_WAIT_OPEN;
               next_r.slice    = '0;
               next_r.ovf      = 1'b0;
               next_r.clk_cnt  = '0;
               next_r.tick_cnt = '0;
               next_r.done     = 1'b0;
               next_r.busy     = 1'b1;
            end
         end
         ST_WAIT_OPEN: begin
            if (expired) begin
               next_r.st        = ST_DIVIDE;
               next_r.count     = cur_count;
               next_r.overflow  = r.ovf;
               next_r.valid     = 1'b0;
               next_r.timeout   = 1'b1;
               next_r.div_start = 1'b1;
            end else if (open_edge) begin
               next_r.st = ST_COUNTING;
            end
         end
         ST_COUNTING: begin
            if (expired) begin
               next_r.st        = ST_DIVIDE;
               next_r.count     = cur_count;
               next_r.overflow  = r.ovf;
               next_r.valid     = 1'b0;
               next_r.timeout   = 1'b1;
               next_r.div_start = 1'b1;
            end else if (close_edge) begin
               if (!r.ovf && cur_count >= MIN_VALID_COUNT) begin
                  next_r.st        = ST_DIVIDE;
                  next_r.count     = cur_count;
                  next_r.overflow  = 1'b0;
                  next_r.valid     = 1'b1;
                  next_r.timeout   = 1'b0;
                  next_r.div_start = 1'b1;
               end else begin
                  // Retry; a period's closing edge opens the next one
                  next_r.slice = '0;
                  next_r.ovf   = 1'b0;
                  next_r.st    = meas_type_in[1] ? ST_COUNTING : ST_WAIT_OPEN;
               end
            end else if (tick) begin
               if (at_tc) begin
                  next_r.ovf = 1'b1;
               end else begin
                  for (int i = 0; i < SLICES; i++) begin
                     if (carry[i]) begin
                        next_r.slice[i] = r.slice[i] + SLICE_W'(1);
                     end
                  end
               end
            end
         end
         ST_DIVIDE: begin
            if (div_done) begin
               next_r.time_ns = quot[TIME_OUT_W-1:0];
               next_r.st      = ST_HOLD;
               next_r.done    = 1'b1;
               next_r.busy    = 1'b0;
            end
         end
         ST_HOLD: begin
            if (read_ack_in) begin
               next_r.st   = ST_IDLE;
               next_r.done = 1'b0;
            end
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         r       <= '0;
         r.st    <= ST_IDLE;
         r.count <= COUNT_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign count_out    = r.count;
   assign time_ns_out  = r.time_ns;
   assign valid_out    = r.valid;
   assign overflow_out = r.overflow;
   assign timeout_out  = r.timeout;
   assign done_out     = r.done;
   assign busy_out     = r.busy;

   // Checks
   a_open_edge: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_WAIT_OPEN && open_edge && !expired) |=> (r.st == ST_COUNTING))
      else $error("interval did not open on its edge");
   a_close_latch: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_COUNTING && close_edge && !expired && !r.ovf &&
       cur_count >= MIN_VALID_COUNT) |=> (r.st == ST_DIVIDE && r.count == $past(cur_count)))
      else $error("count not latched at closing edge");
   a_gate_count: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_COUNTING && tick && !at_tc && !close_edge && !expired && $stable(cascade_in))
      |=> (cur_count == $past(cur_count) + 32'h1))
      else $error("tick not counted");
   a_tb_select: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (timebase_hz_in == TB_INTERNAL_ALT) |-> (tick && den == 32'(INT_TB_HZ)))
      else $error("internal timebase not chosen");
   a_time_report: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_DIVIDE && div_done) |=> (time_ns_out == $past(quot[TIME_OUT_W-1:0]) && done_out))
      else $error("time not reported");
   a_timeout_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      ((r.st == ST_WAIT_OPEN || r.st == ST_COUNTING) && expired)
      |=> (timeout_out && !valid_out && r.st == ST_DIVIDE))
      else $error("timeout not flagged");
   a_cascade_sum: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      cascade_in |-> (cur_count == {r.slice[1], r.slice[0]}))
      else $error("cascade sum wrong");
   a_ovf_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_COUNTING && tick && at_tc && !close_edge && !expired) |=> r.ovf)
      else $error("overflow not set at terminal count");
   a_valid_rule: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      done_out |-> (valid_out == (!overflow_out && !timeout_out &&
                                  count_out >= MIN_VALID_COUNT)))
      else $error("valid flag inconsistent");
   a_hold_stable: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (r.st == ST_HOLD && !read_ack_in) |=> ($stable(count_out) && r.st == ST_HOLD))
      else $error("held result changed");
   a_limit_default: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (use_default_limit_in && r.clk_cnt < 32'(DEF_LIMIT_CYCLES)) |-> !expired)
      else $error("default limit expired early");
endmodule // pulse_width_period_meter

/* rtl/meter_pkg.sv */
// Notes on behaviour
// - Types 0/1 time high or low pulse
// - Types 2/3 time rising or falling period
// - Gate lets timebase ticks into counter
// - Setting 0 or 10000000 selects internal timebase
// - Time reported is count over timebase, always
// - Default limit: five seconds or four ranges, whichever is longer
// - Cascade count is high shifted 16 plus low
// - Terminal count sets overflow, not an error
// - Valid only without overflow and underflow
// - No valid reading in limit sets timeout
package meter_pkg;
   // Measurement type codes
   localparam logic [1:0]  TYPE_HIGH_WIDTH = 2'h0;
   localparam logic [1:0]  TYPE_LOW_WIDTH  = 2'h1;
   localparam logic [1:0]  TYPE_RISE_PER   = 2'h2;
   localparam logic [1:0]  TYPE_FALL_PER   = 2'h3;
   // Timebase settings that select the internal clock
   localparam logic [31:0] TB_INTERNAL_ZERO = 32'h0;
   localparam logic [31:0] TB_INTERNAL_ALT  = 32'd10000000;
   // Counter geometry
   localparam int          SLICE_W       = 16;
   localparam int          SLICES        = 2;
   localparam int          CASCADE_SHIFT = 16;
   localparam logic [31:0] MIN_VALID_COUNT = 32'h4;
   // Timing
   localparam int          CLK_HZ     = 25000000;
   localparam int          TIMEOUT_S  = 5;
   localparam int          RANGE_MULT = 4;
   localparam logic [34:0] TICK_LIMIT_ONE = 35'(RANGE_MULT) << SLICE_W;
   localparam logic [34:0] TICK_LIMIT_TWO = 35'(RANGE_MULT) << (SLICE_W * SLICES);
   localparam logic [63:0] NS_PER_S   = 64'd1000000000;
   localparam int          TIME_OUT_W = 48;
   // Reset values
   localparam logic [31:0] COUNT_RESET = 32'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_OPEN,
      ST_COUNTING,
      ST_DIVIDE,
      ST_HOLD
   } meter_state_e;
endpackage

/* rtl/serial_divider.sv */
module serial_divider
   import meter_pkg::*;
#(
   parameter int NUM_W = 64,
   parameter int DEN_W = 32
) (
   input  wire logic             clock_in,
   input  wire logic             sys_rst_in,
   input  wire logic             start_in,
   input  wire logic [NUM_W-1:0] num_in,
   input  wire logic [DEN_W-1:0] den_in,
   output logic      [NUM_W-1:0] quot_out,
   output logic                  done_out
);
   typedef struct packed {
      logic             busy;
      logic             done;
      logic [6:0]       idx;
      logic [DEN_W-1:0] den;
      logic [NUM_W-1:0] num;
      logic [DEN_W:0]   rem;
      logic [NUM_W-1:0] quot;
   } div_s;

   div_s r;
   div_s next_r;

   // One quotient bit per cycle, restoring
   always_comb begin
      logic [DEN_W:0] shifted;
      shifted = {r.rem[DEN_W-1:0], r.num[NUM_W-1]};
      next_r = r;
      next_r.done = 1'b0;
      if (start_in) begin
         next_r.busy = 1'b1;
         next_r.idx  = 7'(NUM_W - 1);
         next_r.den  = den_in;
         next_r.num  = num_in;
         next_r.rem  = '0;
         next_r.quot = '0;
      end else if (r.busy) begin
         next_r.num = {r.num[NUM_W-2:0], 1'b0};
         if (shifted >= {1'b0, r.den}) begin
            next_r.rem  = shifted - {1'b0, r.den};
            next_r.quot = {r.quot[NUM_W-2:0], 1'b1};
         end else begin
            next_r.rem  = shifted;
            next_r.quot = {r.quot[NUM_W-2:0], 1'b0};
         end
         if (r.idx == 7'h0) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end else begin
            next_r.idx = r.idx - 7'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign quot_out = r.quot;
   assign done_out = r.done;
endmodule // serial_divider

/* test/gate_source.sv */
// Far-side model: square-wave TTL source on the counter gate pin
module gate_source (
   input  wire logic clock_in,
   input  wire logic [31:0] high_in,
   input  wire logic [31:0] low_in,
   input  wire logic        enable_in,
   output logic             gate_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;

   initial gate_out = 1'b0;

   // Idles low; when enabled, low for low_in clocks then high for high_in clocks
   always @(posedge clock_in) begin
      #2;
      if (enable_in !== 1'b1) begin
         gate_out = 1'b0;
         cnt = 0;
      end else begin
         cnt++;
         if (gate_out ? cnt >= high_in : cnt >= low_in) begin
            gate_out = ~gate_out;
            cnt = 0;
         end
      end
   end
endmodule // gate_source

/* test/tb_top.sv */
module tb_top import meter_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] div;
      logic [2:0]  flg;
   } note_s;
   logic        clock_in = 0, sys_rst_in = 1, gate, ext_timebase_in = 0, ext_on = 0;
   logic [1:0]  meas_type_in = 0;
   logic [31:0] timebase_hz_in = 0, limit_cycles_in = 0, count_out, tb_div = 0;
   logic        cascade_in = 0, use_default_limit_in = 1, start_in = 0, read_ack_in = 0;
   logic [TIME_OUT_W-1:0] time_ns_out;
   logic        valid_out, overflow_out, timeout_out, done_out, busy_out, done_q = 0;
   logic        gate_en = 0;
   int          high_c = 0, low_c = 0, n_fail = 0, comparisons = 0, seed = 69180, hc, lc;
   note_s       notes[$];
   note_s       nt;

   pulse_width_period_meter #(.DEF_LIMIT_CYCLES(200)) pulse_width_period_meter_i (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .counter_gate_input_in(gate),
      .ext_timebase_in(ext_timebase_in), .meas_type_in(meas_type_in),
      .timebase_hz_in(timebase_hz_in), .cascade_in(cascade_in),
      .use_default_limit_in(use_default_limit_in), .limit_cycles_in(limit_cycles_in),
      .start_in(start_in), .read_ack_in(read_ack_in), .count_out(count_out),
      .time_ns_out(time_ns_out), .valid_out(valid_out), .overflow_out(overflow_out),
      .timeout_out(timeout_out), .done_out(done_out), .busy_out(busy_out));

   gate_source gate_source_i (.clock_in(clock_in), .high_in(high_c), .low_in(low_c),
      .enable_in(gate_en), .gate_out(gate));

   // 25 MHz clock
   initial forever #20 clock_in = ~clock_in;

   // External timebase: one tick every four clocks while selected
   always @(posedge clock_in) begin
      #2;
      tb_div = tb_div + 32'h1;
      ext_timebase_in = ext_on & tb_div[1];
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] lo, input logic [63:0] hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Result watcher: takes the oldest note when done rises
   always @(negedge clock_in) begin
      if (done_out === 1'b1 && done_q !== 1'b1) begin
         if (notes.size() == 0) begin
            n_fail++;
            $display("BAD t=%0t unexpected result %h", $time, count_out);
         end else begin
            nt = notes.pop_front();
            chk(count_out, nt.lo, nt.hi);
            chk(time_ns_out, nt.lo * NS_PER_S / nt.div, nt.hi * NS_PER_S / nt.div);
            chk(valid_out, nt.flg[2], nt.flg[2]);
            chk(overflow_out, nt.flg[1], nt.flg[1]);
            chk(timeout_out, nt.flg[0], nt.flg[0]);
         end
      end
      done_q = done_out;
   end

   // One measurement: configure, arm, wait, hold, release
   task automatic measure(input logic [1:0] typ, input logic [31:0] hz, input logic casc,
                          input logic [31:0] lim, input int h, input int l,
                          input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] div, input logic [2:0] flg);
      logic [31:0] held;
      int k;
      meas_type_in = typ;
      timebase_hz_in = hz;
      cascade_in = casc;
      use_default_limit_in = (lim == 0);
      limit_cycles_in = lim;
      high_c = h;
      low_c = l;
      ext_on = (hz != 32'h0 && hz != 32'd10000000);
      repeat (5) @(posedge clock_in);
      #2;
      notes.push_back(note_s'{lo, hi, div, flg});
      start_in = 1'b1;
      gate_en = (h != 0);
      @(posedge clock_in);
      #2;
      start_in = 1'b0;
      chk(busy_out, 1, 1);
      k = 0;
      while (done_out !== 1'b1 && k < 100000) begin
         @(posedge clock_in);
         #2;
         k++;
      end
      chk(done_out, 1, 1);
      held = count_out;
      repeat (60) @(posedge clock_in);
      #2;
      chk(count_out, held, held);
      read_ack_in = 1'b1;
      @(posedge clock_in);
      #2;
      read_ack_in = 1'b0;
      gate_en = 1'b0;
      @(posedge clock_in);
      #2;
      chk(done_out, 0, 0);
      $display("Test type %0d hz %0d done, count %h", typ, hz, held);
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clock_in);
      #2;
      sys_rst_in = 1'b0;
      chk({done_out, busy_out, valid_out, count_out}, 0, 0);
      for (int t = 0; t < 4; t++) begin
         hc = 20 + ($random(seed) & 15);
         lc = 20 + ($random(seed) & 15);
         lc = (t == 1) ? lc : (t == 0) ? hc : hc + lc;
         measure(t[1:0], 0, 0, 0, hc, (t == 1 || t == 0) ? lc : lc - hc,
                 lc - 1, lc + 1, 25000000, 3'b100);
      end
      measure(2, 32'd10000000, 0, 0, 30, 50, 79, 81, 25000000, 3'b100);
      measure(2, 32'd1000, 0, 0, 30, 50, 19, 21, 1000, 3'b100);
      measure(2, 0, 1, 0, 30, 50, 79, 81, 25000000, 3'b100);
      measure(2, 0, 0, 300, 0, 0, 0, 0, 25000000, 3'b001);
      measure(0, 0, 0, 400, 2, 20, 0, 3, 25000000, 3'b001);
      measure(0, 0, 0, 67000, 80000, 10, 32'hffff, 32'hffff, 25000000, 3'b011);
      print_verdict();
   end

   // Watchdog
   initial begin
      #(90000 * 40);
      n_fail++;
      print_verdict();
   end
endmodule // tb_top
